// [rtl/updown_counter.v]
// Reversible 4-bit counter with up/down count inputs, load, clear, carry and borrow
// Assumes all inputs other than clk and rst_n arrive asynchronously to clk and are sampled by it
//
// Behaviour
// - Four-bit count steps up or down and wraps within four bits.
// - All four bits update together on the rising edge of the pulsed input.
// - Direction follows the pulsed input; the other input is held high.
// - While load is low, the count follows the four data inputs.
// - High clear forces count to zero over load and count inputs.
// - Up from 15 wraps to 0 with carry; down from 0 wraps to 15.
// - Borrow pulse width matches the count-down pulse that causes it.
// - Carry pulse width matches the count-up pulse that causes it.
`timescale 1ns/1ps
`include "updown_counter_regs.vh"

module updown_counter (
   input wire clk,
   input wire rst_n,
   input wire count_up,
   input wire count_down,
   input wire load_n,
   input wire clear,
   input wire [3:0] data_in,
   output wire count_bit0,
   output wire count_bit1,
   output wire count_bit2,
   output wire count_bit3,
   output reg carry_n,
   output reg borrow_n
);

   // ----------------------------------------
   // Input samplers
   // ----------------------------------------
   reg [2:0] up_s_r;
   reg [2:0] dn_s_r;
   reg [2:0] ld_s_r;
   reg [2:0] clr_s_r;
   reg [2:0] d0_s_r;
   reg [2:0] d1_s_r;
   reg [2:0] d2_s_r;
   reg [2:0] d3_s_r;
   reg up_r;
   reg dn_r;
   reg ld_n_r;
   reg clr_r;
   reg [3:0] din_r;
   reg [3:0] cnt_r;
   reg [3:0] cnt_nxt;
   reg carry_nxt;
   reg borrow_nxt;
   wire up_rise;
   wire dn_rise;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         up_s_r <= `SYNC_RESET;
      end else begin
         up_s_r <= {up_s_r[1:0], count_up};
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dn_s_r <= `SYNC_RESET;
      end else begin
         dn_s_r <= {dn_s_r[1:0], count_down};
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ld_s_r <= `SYNC_RESET;
      end else begin
         ld_s_r <= {ld_s_r[1:0], load_n};
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clr_s_r <= `SYNC_LOW;
      end else begin
         clr_s_r <= {clr_s_r[1:0], clear};
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         d0_s_r <= `SYNC_LOW;
      end else begin
         d0_s_r <= {d0_s_r[1:0], data_in[0]};
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         d1_s_r <= `SYNC_LOW;
      end else begin
         d1_s_r <= {d1_s_r[1:0], data_in[1]};
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         d2_s_r <= `SYNC_LOW;
      end else begin
         d2_s_r <= {d2_s_r[1:0], data_in[2]};
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         d3_s_r <= `SYNC_LOW;
      end else begin
         d3_s_r <= {d3_s_r[1:0], data_in[3]};
      end
   end

   // ----------------------------------------
   // Agreed levels
   // ----------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         up_r <= 1'b1;
      end else if (up_s_r[1] == up_s_r[2]) begin
         up_r <= up_s_r[2];
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dn_r <= 1'b1;
      end else if (dn_s_r[1] == dn_s_r[2]) begin
         dn_r <= dn_s_r[2];
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ld_n_r <= 1'b1;
      end else if (ld_s_r[1] == ld_s_r[2]) begin
         ld_n_r <= ld_s_r[2];
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clr_r <= 1'b0;
      end else if (clr_s_r[1] == clr_s_r[2]) begin
         clr_r <= clr_s_r[2];
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         din_r[0] <= 1'b0;
      end else if (d0_s_r[1] == d0_s_r[2]) begin
         din_r[0] <= d0_s_r[2];
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         din_r[1] <= 1'b0;
      end else if (d1_s_r[1] == d1_s_r[2]) begin
         din_r[1] <= d1_s_r[2];
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         din_r[2] <= 1'b0;
      end else if (d2_s_r[1] == d2_s_r[2]) begin
         din_r[2] <= d2_s_r[2];
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         din_r[3] <= 1'b0;
      end else if (d3_s_r[1] == d3_s_r[2]) begin
         din_r[3] <= d3_s_r[2];
      end
   end

   // Rising edge seen once both late stages agree high
   assign up_rise = !up_r && up_s_r[1] && up_s_r[2];
   assign dn_rise = !dn_r && dn_s_r[1] && dn_s_r[2];

   // ----------------------------------------
   // Count
   // ----------------------------------------
   always @* begin
      cnt_nxt = cnt_r;
      if (clr_r) begin
         cnt_nxt = `CNT_ZERO;
      end else if (!ld_n_r) begin
         cnt_nxt = din_r;
      end else if (up_rise && dn_r) begin
         cnt_nxt = cnt_r + `CNT_STEP;
      end else if (dn_rise && up_r) begin
         cnt_nxt = cnt_r - `CNT_STEP;
      end
   end

   // ----------------------------------------
   // Carry and borrow
   // ----------------------------------------
   always @* begin
      // Low only while the input is low at the limit value
      carry_nxt = !(!up_r && cnt_r == `CNT_MAX && !clr_r && ld_n_r);
      borrow_nxt = !(!dn_r && cnt_r == `CNT_ZERO && !clr_r && ld_n_r);
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= `CNT_RESET;
         carry_n <= 1'b1;
         borrow_n <= 1'b1;
      end else begin
         cnt_r <= cnt_nxt;
         carry_n <= carry_nxt;
         borrow_n <= borrow_nxt;
      end
   end

   assign count_bit0 = cnt_r[0];
   assign count_bit1 = cnt_r[1];
   assign count_bit2 = cnt_r[2];
   assign count_bit3 = cnt_r[3];

endmodule // updown_counter

// [rtl/updown_counter_regs.vh]
// Constants for the reversible 4-bit counter
// Assumes inclusion by the counter module only
`ifndef UPDOWN_COUNTER_REGS_VH
`define UPDOWN_COUNTER_REGS_VH

// ----------------------------------------
// Count field
// ----------------------------------------
`define CNT_WIDTH 4
`define CNT_MAX 4'hF
`define CNT_ZERO 4'h0
`define CNT_RESET 4'h0
`define CNT_STEP 4'h1

// ----------------------------------------
// Input sampler
// ----------------------------------------
`define SYNC_RESET 3'h7
`define SYNC_LOW 3'h0

`endif

// [test/next_stage.sv]
// Next cascaded stage counting carry and borrow
// Assumes clk much faster than those pulses
`timescale 1ns/1ps
module next_stage (
   input clk,
   input carry_n,
   input borrow_n,
   output reg [3:0] hi = 4'h0
);
   reg pc = 1'h1, pb = 1'h1;
   always @(posedge clk) begin
      {pc, pb} <= {carry_n, borrow_n};
      hi <= hi + (carry_n & !pc) - (borrow_n & !pb);
   end
endmodule // next_stage

// [test/test_updown_counter.sv]
// Bench for the counter with a next stage
// Needs rtl in the include path
`timescale 1ns/1ps
module test_updown_counter;
   reg clk = 1'h0, rst_n = 1'h0, count_up = 1'h1, count_down = 1'h1, load_n = 1'h1;
   reg clear = 1'h0;
   reg [3:0] data_in = 4'h0, e = 4'h0, h = 4'h0;
   wire count_bit0, count_bit1, count_bit2, count_bit3, carry_n, borrow_n;
   wire [3:0] hi, q = {count_bit3, count_bit2, count_bit1, count_bit0};
   reg [7:0] eq[$];
   event ev;
   int fail_count = 0, n_checks = 0, i;
   initial forever #20 clk = !clk;
   updown_counter dut (.*);
   next_stage far (.*);
   task cmp(input string n, input [3:0] x, input [3:0] g);
      n_checks++;
      if (g !== x) begin
         fail_count++;
         $display("unexpected %s exp %h got %h", n, x, g);
      end
   endtask
   task close_out;
      $display("checks %0d fails %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Kinds: 0 up, 1 down, 2 load, 3 clear over load
   task op(input [1:0] k, input [3:0] v);
      data_in = v;
      @(negedge clk);
      {count_up, count_down, load_n, clear} = {k != 2'h0, k != 2'h1, !k[1], &k};
      repeat (5) @(negedge clk);
      {count_up, count_down, load_n, clear} = 4'hE;
      repeat (6) @(negedge clk);
      h = h + (k == 2'h0 && e == 4'hF) - (k == 2'h1 && e == 4'h0);
      e = k[1] ? v & {4{!k[0]}} : e + (k ? 4'hF : 4'h1);
      eq.push_back({h, e});
      -> ev;
   endtask
   initial begin
      void'($urandom(32'hDEC2));
      repeat (2) @(negedge clk);
      rst_n = 1'h1;
      op(2'h2, 4'hD);
      for (i = 0; i < 7; i++) op({1'h0, i > 3}, 4'h0);
      $display("wrap done");
      for (i = 0; i < 24; i++) op(2'($urandom), 4'($urandom));
      $display("random done");
      close_out;
   end
   initial forever begin
      @ev;
      cmp("count", eq[0][3:0], q);
      cmp("next", eq[0][7:4], hi);
      eq.pop_front();
   end
   initial begin
      #50000;
      fail_count++;
      close_out;
   end
endmodule // test_updown_counter

// [test/updown_counter_assertions.sv]
// Checker on the counter ports
// Bound into updown_counter
`timescale 1ns/1ps
module udc_chk (input clk, rst_n, count_up, count_down, load_n, clear, input [3:0] data_in,
   input count_bit0, count_bit1, count_bit2, count_bit3, carry_n, borrow_n);
   wire [3:0] q = {count_bit3, count_bit2, count_bit1, count_bit0};
   wire ok = load_n & !clear;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_CLR: assert property (clear [*5] |=> q == 4'h0) else $error("clr");
   AST_LD: assert property ((!load_n && !clear && $stable(data_in)) [*5]
      |=> q == data_in) else $error("ld");
   AST_UP: assert property (ok [*8] ##0 q == $past(q) + 4'h1 |->
      $past(count_up, 4) > $past(count_up, 5)) else $error("up");
   AST_DN: assert property (ok [*8] ##0 q == $past(q) - 4'h1 |->
      $past(count_down, 4) > $past(count_down, 5)) else $error("dn");
   AST_CY: assert property (!carry_n |-> q == 4'hF || $past(q) == 4'hF)
      else $error("cy");
   AST_BW: assert property (!borrow_n |-> q == 4'h0 || $past(q) == 4'h0)
      else $error("bw");
   AST_CW: assert property (!carry_n |-> !$past(count_up, 5)) else $error("cw");
   AST_BWW: assert property (!borrow_n |-> !$past(count_down, 5)) else $error("bw");
endmodule // udc_chk
bind updown_counter udc_chk chk (.*);
